// [hw/vsc_map.svh]
// Opcodes, field positions, reset values and row limits of the voice store command handler
`ifndef VSC_MAP_SVH
`define VSC_MAP_SVH

`define VSC_OP_CFG_PIN_LVL   8'h45
`define VSC_OP_CFG_BIT_LVL   8'h65
`define VSC_OP_SAVE_NV       8'h46
`define VSC_OP_LOAD_NV       8'h47
`define VSC_OP_SET_PLAY      8'h80
`define VSC_OP_SET_REC       8'h81
`define VSC_ZERO_BYTE        8'h00

`define VSC_CFG_W            12
`define VSC_CFG_LO_W         8
`define VSC_CFG_HI_W         4
`define VSC_LVL_W            3
`define VSC_ROW_W            11
`define VSC_ROW_HI_W         3
`define VSC_STATUS_ERR_BIT   0

`define VSC_CFG_RESET        12'h000
`define VSC_NV_RESET         12'h000
`define VSC_WRAP_ROW         11'h010
`define VSC_LAST_ROW         11'h7FF

`define VSC_RANGE_BYTES      3'h7
`define VSC_CFG_BYTES        3'h3
`define VSC_NV_BYTES         3'h2
`endif

// [hw/vsc_pkg.sv]
// Types shared by the voice store command handler
`include "vsc_map.svh"
package vsc_pkg;
  typedef struct packed {
    logic [`VSC_ROW_W-1:0] start_row;
    logic [`VSC_ROW_W-1:0] end_row;
  } vsc_range_t;

  typedef enum logic [2:0] {
    VSC_CMD_NONE,
    VSC_CMD_CFG,
    VSC_CMD_SAVE,
    VSC_CMD_LOAD,
    VSC_CMD_RANGE
  } vsc_cmd_t;
endpackage

// [hw/vsc_row_seq.sv]
// Row sequencer for address-range operations with one preloaded pair
`timescale 1ns/1ns
`include "vsc_map.svh"
module vsc_row_seq #(
  parameter logic [`VSC_ROW_W-1:0] LAST_ROW = `VSC_LAST_ROW,
  parameter logic [`VSC_ROW_W-1:0] WRAP_ROW = `VSC_WRAP_ROW
) (
  // Clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  resetn,
  // Range loading
  input  wire logic                  range_load,
  input  vsc_pkg::vsc_range_t        range_in,
  // Array progress
  input  wire logic                  row_step,
  // State
  output logic [`VSC_ROW_W-1:0]      row_reg,
  output logic                       active_reg,
  output logic                       pending_reg,
  output logic                       done_reg
);
  logic [`VSC_ROW_W-1:0] row_next;
  logic [`VSC_ROW_W-1:0] end_reg;
  logic [`VSC_ROW_W-1:0] end_next;
  logic                  active_next;
  logic                  pending_next;
  logic                  done_next;
  vsc_pkg::vsc_range_t   pend_reg;
  vsc_pkg::vsc_range_t   pend_next;

  always_comb begin
    row_next     = row_reg;
    end_next     = end_reg;
    active_next  = active_reg;
    pending_next = pending_reg;
    pend_next    = pend_reg;
    done_next    = 1'b0;
    if (active_reg && row_step) begin
      if (row_reg == end_reg) begin
        if (pending_reg) begin
          // Jump straight on, no idle row between the two ranges
          row_next     = pend_reg.start_row;
          end_next     = pend_reg.end_row;
          pending_next = 1'b0;
        end else begin
          active_next = 1'b0;
          done_next   = 1'b1;
        end
      end else if (row_reg == LAST_ROW) begin
        // Wrap skips the effect rows; after a wrap an end among them never matches
        row_next = WRAP_ROW;
      end else begin
        row_next = row_reg + 1'b1;
      end
    end
    if (range_load) begin
      if (!active_next) begin
        row_next    = range_in.start_row;
        end_next    = range_in.end_row;
        active_next = 1'b1;
      end else begin
        pend_next    = range_in;
        pending_next = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      row_reg     <= '0;
      end_reg     <= '0;
      active_reg  <= 1'b0;
      pending_reg <= 1'b0;
      pend_reg    <= '0;
      done_reg    <= 1'b0;
    end else begin
      row_reg     <= row_next;
      end_reg     <= end_next;
      active_reg  <= active_next;
      pending_reg <= pending_next;
      pend_reg    <= pend_next;
      done_reg    <= done_next;
    end
  end
endmodule

// [hw/vsc_cmd.sv]
// Serial command handler: analog path configuration and range commands
`timescale 1ns/1ns
`include "vsc_map.svh"
module vsc_cmd #(
  parameter logic [`VSC_CFG_W-1:0] CFG_RESET = `VSC_CFG_RESET,
  parameter logic [`VSC_CFG_W-1:0] NV_RESET  = `VSC_NV_RESET,
  parameter logic [`VSC_ROW_W-1:0] LAST_ROW  = `VSC_LAST_ROW
) (
  // Clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  resetn,
  // Serial port, mode 3, LSB first
  input  wire logic                  spi_sclk,
  input  wire logic                  spi_mosi,
  input  wire logic                  spi_ss_n,
  output logic                       spi_miso,
  output logic                       spi_miso_oe,
  // Device context
  input  wire logic [`VSC_LVL_W-1:0] volume_pin,
  input  wire logic                  ext_busy,
  input  wire logic [6:0]            status_aux,
  input  wire logic                  row_step,
  // Configuration outputs
  output logic [`VSC_CFG_W-1:0]      analog_path_config,
  output logic [`VSC_CFG_W-1:0]      config_nonvolatile_copy,
  output logic [`VSC_LVL_W-1:0]      volume_level,
  output logic                       volume_from_bits,
  output logic                       cmd_error,
  // Range operation
  output logic [`VSC_ROW_W-1:0]      row_addr,
  output logic                       row_active,
  output logic                       row_pending,
  output logic                       row_record,
  output logic                       range_done
);
  // Serial engine state
  logic                   sclk_reg;
  logic                   ss_n_reg;
  logic [2:0]             bit_reg;
  logic [2:0]             bit_next;
  logic [7:0]             rx_reg;
  logic [7:0]             rx_next;
  logic [7:0]             tx_reg;
  logic [7:0]             tx_next;
  logic                   miso_reg;
  logic                   miso_next;
  logic [2:0]             byte_reg;
  logic [2:0]             byte_next;
  logic [5:1][7:0]        arg_reg;
  logic [5:1][7:0]        arg_next;
  logic [7:0]             op_reg;
  logic [7:0]             op_next;
  vsc_pkg::vsc_cmd_t      cmd_reg;
  vsc_pkg::vsc_cmd_t      cmd_next;
  // Configuration state
  logic [`VSC_CFG_W-1:0]  cfg_reg;
  logic [`VSC_CFG_W-1:0]  cfg_next;
  logic [`VSC_CFG_W-1:0]  nv_reg;
  logic [`VSC_CFG_W-1:0]  nv_next;
  logic                   vsel_reg;
  logic                   vsel_next;
  logic [`VSC_LVL_W-1:0]  lvl_reg;
  logic [`VSC_LVL_W-1:0]  lvl_next;
  logic                   boot_reg;
  logic                   err_reg;
  logic                   err_next;
  logic                   rec_reg;
  logic                   rec_next;
  logic                   oe_reg;
  // Range handoff
  logic                   range_load;
  vsc_pkg::vsc_range_t    range_in;
  logic                   seq_active;
  logic                   seq_pending;
  logic                   idle;
  logic                   rise;
  logic                   fall;
  logic                   byte_done;
  logic [7:0]             rx_byte;
  logic [7:0]             status_byte;

  assign rise        = spi_sclk & ~sclk_reg & ~spi_ss_n;
  assign fall        = ~spi_sclk & sclk_reg & ~spi_ss_n;
  assign byte_done   = rise && (bit_reg == 3'h7);
  assign rx_byte     = {spi_mosi, rx_reg[7:1]};
  assign idle        = ~ext_busy & ~seq_active;
  assign status_byte = {status_aux, err_reg};

  // Serial bit and byte framing
  always_comb begin
    bit_next  = bit_reg;
    rx_next   = rx_reg;
    tx_next   = tx_reg;
    miso_next = miso_reg;
    byte_next = byte_reg;
    if (spi_ss_n) begin
      bit_next  = 3'h0;
      byte_next = 3'h0;
    end else begin
      if (rise) begin
        rx_next  = rx_byte;
        bit_next = bit_reg + 3'h1;
        if (byte_done && byte_reg != 3'h7) begin
          byte_next = byte_reg + 3'h1;
        end
      end
      if (fall) begin
        if (bit_reg == 3'h0) begin
          // Every byte slot echoes status, the opcode slot included
          miso_next = status_byte[0];
          tx_next   = {1'b0, status_byte[7:1]};
        end else begin
          miso_next = tx_reg[0];
          tx_next   = {1'b0, tx_reg[7:1]};
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sclk_reg <= 1'b1;
      ss_n_reg <= 1'b1;
      bit_reg  <= 3'h0;
      rx_reg   <= 8'h00;
      tx_reg   <= 8'h00;
      miso_reg <= 1'b0;
      byte_reg <= 3'h0;
      oe_reg   <= 1'b0;
    end else begin
      sclk_reg <= spi_sclk;
      ss_n_reg <= spi_ss_n;
      bit_reg  <= bit_next;
      rx_reg   <= rx_next;
      tx_reg   <= tx_next;
      miso_reg <= miso_next;
      byte_reg <= byte_next;
      oe_reg   <= ~spi_ss_n;
    end
  end

  // Command decode and execution
  always_comb begin
    op_next    = op_reg;
    cmd_next   = cmd_reg;
    arg_next   = arg_reg;
    cfg_next   = cfg_reg;
    nv_next    = nv_reg;
    vsel_next  = vsel_reg;
    rec_next   = rec_reg;
    err_next   = err_reg;
    range_load = 1'b0;
    range_in   = '0;
    // The flag is read out with the opcode byte, then cleared
    if (fall && bit_reg == 3'h0 && byte_reg == 3'h0) begin
      err_next = 1'b0;
    end
    if (boot_reg) begin
      cfg_next = nv_reg;
    end
    if (byte_done) begin
      unique case (byte_reg)
        3'h0: begin
          op_next = rx_byte;
          if (rx_byte == `VSC_OP_CFG_PIN_LVL || rx_byte == `VSC_OP_CFG_BIT_LVL) begin
            cmd_next = vsc_pkg::VSC_CMD_CFG;
          end else if (rx_byte == `VSC_OP_SAVE_NV) begin
            cmd_next = vsc_pkg::VSC_CMD_SAVE;
          end else if (rx_byte == `VSC_OP_LOAD_NV) begin
            cmd_next = vsc_pkg::VSC_CMD_LOAD;
          end else if (rx_byte == `VSC_OP_SET_PLAY || rx_byte == `VSC_OP_SET_REC) begin
            cmd_next = vsc_pkg::VSC_CMD_RANGE;
          end else begin
            cmd_next = vsc_pkg::VSC_CMD_NONE;
          end
        end
        3'h1, 3'h2, 3'h3, 3'h4, 3'h5: arg_next[byte_reg] = rx_byte;
        default: ;
      endcase
      // Configuration write completes on its third byte
      if (cmd_reg == vsc_pkg::VSC_CMD_CFG && byte_reg == `VSC_CFG_BYTES - 3'h1) begin
        cfg_next  = {rx_byte[`VSC_CFG_HI_W-1:0], arg_reg[1]};
        vsel_next = (op_reg == `VSC_OP_CFG_BIT_LVL);
        cmd_next  = vsc_pkg::VSC_CMD_NONE;
      end
      // Save and load need a zero second byte and an idle device
      if ((cmd_reg == vsc_pkg::VSC_CMD_SAVE || cmd_reg == vsc_pkg::VSC_CMD_LOAD)
          && byte_reg == `VSC_NV_BYTES - 3'h1) begin
        if (!idle) begin
          err_next = 1'b1;
        end else if (rx_byte == `VSC_ZERO_BYTE) begin
          if (cmd_reg == vsc_pkg::VSC_CMD_SAVE) begin
            nv_next = cfg_reg;
          end else begin
            cfg_next = nv_reg;
          end
        end
        cmd_next = vsc_pkg::VSC_CMD_NONE;
      end
      if (cmd_reg == vsc_pkg::VSC_CMD_RANGE && byte_reg == `VSC_RANGE_BYTES - 3'h1) begin
        range_in.start_row = {arg_reg[3][`VSC_ROW_HI_W-1:0], arg_reg[2]};
        range_in.end_row   = {arg_reg[5][`VSC_ROW_HI_W-1:0], arg_reg[4]};
        if (ext_busy || seq_pending
            || (seq_active && rec_reg != (op_reg == `VSC_OP_SET_REC))) begin
          err_next = 1'b1;
        end else begin
          range_load = 1'b1;
          rec_next   = (op_reg == `VSC_OP_SET_REC);
        end
        cmd_next = vsc_pkg::VSC_CMD_NONE;
      end
    end
    if (spi_ss_n) begin
      cmd_next = vsc_pkg::VSC_CMD_NONE;
    end
  end

  // Pin volume is resampled every cycle; bit volume follows the register
  always_comb begin
    lvl_next = vsel_reg ? cfg_reg[`VSC_LVL_W-1:0] : volume_pin;
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      op_reg   <= 8'h00;
      cmd_reg  <= vsc_pkg::VSC_CMD_NONE;
      arg_reg  <= '0;
      cfg_reg  <= CFG_RESET;
      nv_reg   <= NV_RESET;
      vsel_reg <= 1'b0;
      lvl_reg  <= '0;
      boot_reg <= 1'b1;
      err_reg  <= 1'b0;
      rec_reg  <= 1'b0;
    end else begin
      op_reg   <= op_next;
      cmd_reg  <= cmd_next;
      arg_reg  <= arg_next;
      cfg_reg  <= cfg_next;
      nv_reg   <= nv_next;
      vsel_reg <= vsel_next;
      lvl_reg  <= lvl_next;
      boot_reg <= 1'b0;
      err_reg  <= err_next;
      rec_reg  <= rec_next;
    end
  end

  vsc_row_seq #(
    .LAST_ROW (LAST_ROW),
    .WRAP_ROW (`VSC_WRAP_ROW)
  ) u_seq (
    .ref_clk     (ref_clk),
    .resetn      (resetn),
    .range_load  (range_load),
    .range_in    (range_in),
    .row_step    (row_step),
    .row_reg     (row_addr),
    .active_reg  (seq_active),
    .pending_reg (seq_pending),
    .done_reg    (range_done)
  );

  assign spi_miso                = miso_reg;
  assign spi_miso_oe             = oe_reg;
  assign analog_path_config      = cfg_reg;
  assign config_nonvolatile_copy = nv_reg;
  assign volume_level            = lvl_reg;
  assign volume_from_bits        = vsel_reg;
  assign cmd_error               = err_reg;
  assign row_active              = seq_active;
  assign row_pending             = seq_pending;
  assign row_record              = rec_reg;
endmodule

// [sim/vsc_cmd_props.sv]
// Port-level checks of the voice store command handler
`timescale 1ns/1ns
`include "vsc_map.svh"
module vsc_cmd_props #(
  parameter logic [`VSC_ROW_W-1:0] LAST_ROW = `VSC_LAST_ROW
) (
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        resetn,
  // Inputs
  input wire logic        spi_ss_n,
  input wire logic [2:0]  volume_pin,
  input wire logic        ext_busy,
  input wire logic        row_step,
  // Outputs
  input wire logic        spi_miso_oe,
  input wire logic [11:0] analog_path_config,
  input wire logic [11:0] config_nonvolatile_copy,
  input wire logic [2:0]  volume_level,
  input wire logic        volume_from_bits,
  input wire logic [10:0] row_addr,
  input wire logic        row_active,
  input wire logic        row_pending,
  input wire logic        range_done
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  sequence s_mid_step;
    row_step && row_active && !row_pending && row_addr != LAST_ROW;
  endsequence
  sequence s_wrap_step;
    row_step && row_active && !row_pending && row_addr == LAST_ROW;
  endsequence

  a_level_from_bits: assert property ($past(resetn) && volume_from_bits &&
    $past(volume_from_bits) && $stable(analog_path_config)
    |-> volume_level == analog_path_config[2:0]) else $error("volume not from bits");
  a_level_from_pin: assert property ($past(resetn) && !$past(volume_from_bits)
    |-> volume_level == $past(volume_pin)) else $error("volume not from pin");
  a_miso_oe_lag: assert property ($past(resetn)
    |-> spi_miso_oe == !$past(spi_ss_n)) else $error("miso enable wrong");
  a_cfg_in_frame: assert property ($changed(analog_path_config)
    |-> !$past(spi_ss_n)) else $error("config changed outside frame");
  a_nv_copy_cfg: assert property ($changed(config_nonvolatile_copy)
    |-> config_nonvolatile_copy == $past(analog_path_config)) else $error("save value wrong");
  a_nv_when_idle: assert property ($changed(config_nonvolatile_copy)
    |-> !$past(ext_busy) && !$past(row_active)) else $error("save while busy");
  a_row_advance: assert property (s_mid_step ##1 row_active
    |-> row_addr == $past(row_addr) + 11'h001) else $error("row not advanced");
  a_row_wrap: assert property (s_wrap_step ##1 row_active
    |-> row_addr == 11'h010) else $error("wrap row wrong");
  a_done_single: assert property (range_done
    |-> !row_active && !row_pending ##1 !range_done) else $error("done pulse wrong");
  a_pending_join: assert property ($fell(row_pending)
    |-> row_active) else $error("gap after pending pair");
endmodule

bind vsc_cmd vsc_cmd_props #(.LAST_ROW(LAST_ROW)) vsc_cmd_props_inst (.ref_clk, .resetn,
  .spi_ss_n, .volume_pin, .ext_busy, .row_step, .spi_miso_oe, .analog_path_config,
  .config_nonvolatile_copy, .volume_level, .volume_from_bits, .row_addr, .row_active,
  .row_pending, .range_done);

// [sim/vsc_spi_host.sv]
// Serial host model: mode 3 frames, LSB first, status taken on the opcode byte
`timescale 1ns/1ns
module vsc_spi_host (
  // Clock
  input  wire logic ref_clk,
  // Serial lines
  input  wire logic spi_miso,
  output logic      spi_sclk,
  output logic      spi_mosi,
  output logic      spi_ss_n
);
  initial begin
    spi_sclk = 1'b1;
    spi_mosi = 1'b1;
    spi_ss_n = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  // Long low phase lets the registered answer settle before it is sampled
  task automatic frame(input logic [7:0] q[$], output logic [7:0] status);
    status = 8'h00;
    spi_ss_n = 1'b0;
    tick(2);
    foreach (q[i]) begin
      for (int b = 0; b < 8; b++) begin
        spi_sclk = 1'b0;
        spi_mosi = q[i][b];
        tick(4);
        if (i == 0) status[b] = spi_miso;
        spi_sclk = 1'b1;
        tick(2);
      end
    end
    spi_ss_n = 1'b1;
    // Released line shows no stale bit
    spi_mosi = ~spi_mosi;
    tick(3);
  endtask
endmodule

// [sim/vsc_cmd_tb.sv]
// Self-checking bench for the voice store command handler
`timescale 1ns/1ns
`include "vsc_map.svh"
module vsc_cmd_tb;
  logic        ref_clk = 1'b0, resetn = 1'b0, ext_busy = 1'b0, row_step = 1'b0;
  logic [2:0]  volume_pin = 3'h5;
  logic [6:0]  status_aux = 7'h2A;
  logic        spi_sclk, spi_mosi, spi_ss_n, spi_miso, spi_miso_oe;
  logic        volume_from_bits, cmd_error, row_active, row_pending, row_record, range_done;
  logic [2:0]  volume_level;
  logic [10:0] row_addr;
  logic [11:0] analog_path_config, config_nonvolatile_copy;
  logic [11:0] e_cfg = 12'h000, e_nv = 12'h000;
  logic        e_vsel = 1'b0, e_err = 1'b0;
  logic [7:0]  st = 8'h00, e_st = 8'h00;
  logic [31:0] d;
  logic [37:0] cfg_q[$];
  logic [14:0] row_q[$];
  int          fails = 0, tests_run = 0, cycles = 0, seed = 62546;
  event        cfg_ev, row_ev;
  logic [10:0] rows[6] = '{11'h7FE, 11'h7FF, 11'h010, 11'h011, 11'h020, 11'h021};

  always #5 ref_clk = ~ref_clk;

  vsc_cmd vsc_cmd_inst (.ref_clk, .resetn, .spi_sclk, .spi_mosi, .spi_ss_n, .spi_miso,
    .spi_miso_oe, .volume_pin, .ext_busy, .status_aux, .row_step, .analog_path_config,
    .config_nonvolatile_copy, .volume_level, .volume_from_bits, .cmd_error, .row_addr,
    .row_active, .row_pending, .row_record, .range_done);
  vsc_spi_host vsc_spi_host_inst (.ref_clk, .spi_miso, .spi_sclk, .spi_mosi, .spi_ss_n);

  task automatic compare_cfg(input logic [37:0] got, input logic [37:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic compare_row(input logic [14:0] got, input logic [14:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  // Watchers take the oldest note whenever a result is announced
  always @(cfg_ev) compare_cfg({st, analog_path_config, config_nonvolatile_copy,
    volume_from_bits, cmd_error, row_active, volume_level}, cfg_q.pop_front());
  always @(row_ev) compare_row({row_addr & {11{row_active}}, row_active, row_pending,
    row_record, range_done}, row_q.pop_front());

  task automatic send(input logic [7:0] q[$]);
    e_st = {status_aux, e_err};
    vsc_spi_host_inst.frame(q, st);
  endtask
  task automatic note_cfg();
    cfg_q.push_back({e_st, e_cfg, e_nv, e_vsel, e_err, 1'b0, e_vsel ? e_cfg[2:0] : volume_pin});
    -> cfg_ev;
  endtask
  task automatic note_row(input logic [14:0] e);
    row_q.push_back(e);
    -> row_ev;
  endtask
  // A low cycle between pulses keeps each edge of the strobe apart
  task automatic step();
    @(posedge ref_clk) #1 row_step = 1'b1;
    @(posedge ref_clk) #1 row_step = 1'b0;
  endtask

  task automatic results();
    $display("tests_run %0d fails %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      results();
    end
  end

  initial begin
    repeat (6) @(posedge ref_clk);
    #1 resetn = 1'b1;
    vsc_spi_host_inst.tick(2);
    note_cfg();
    for (int k = 0; k < 4; k++) begin
      d = $random(seed);
      // Volume only moves while idle
      volume_pin = d[18:16];
      e_cfg = d[11:0];
      e_vsel = k[0];
      send('{k[0] ? `VSC_OP_CFG_BIT_LVL : `VSC_OP_CFG_PIN_LVL, d[7:0], d[15:8]});
      note_cfg();
    end
    send('{`VSC_OP_SAVE_NV, `VSC_ZERO_BYTE});
    e_nv = e_cfg;
    note_cfg();
    send('{`VSC_OP_CFG_PIN_LVL, 8'hC3, 8'hF0});
    e_cfg = 12'h0C3;
    e_vsel = 1'b0;
    note_cfg();
    ext_busy = 1'b1;
    send('{`VSC_OP_SAVE_NV, `VSC_ZERO_BYTE});
    e_err = 1'b1;
    note_cfg();
    send('{`VSC_OP_LOAD_NV, `VSC_ZERO_BYTE});
    note_cfg();
    ext_busy = 1'b0;
    send('{`VSC_OP_SAVE_NV, 8'h01});
    e_err = 1'b0;
    note_cfg();
    send('{`VSC_OP_LOAD_NV, `VSC_ZERO_BYTE});
    e_cfg = e_nv;
    note_cfg();
    resetn = 1'b0;
    vsc_spi_host_inst.tick(2);
    resetn = 1'b1;
    vsc_spi_host_inst.tick(2);
    // The status seen last stays with the host across the reset
    e_nv = `VSC_NV_RESET;
    e_cfg = e_nv;
    e_vsel = 1'b0;
    note_cfg();
    send('{`VSC_OP_SET_PLAY, 8'h00, 8'hFE, 8'h07, 8'h11, 8'h00, 8'h00});
    note_row({rows[0], 4'b1000});
    for (int k = 1; k < 6; k++) begin
      // Second pair keeps clear of the effect rows and arrives after the wrap
      if (k == 3) begin
        send('{`VSC_OP_SET_PLAY, 8'h00, 8'h20, 8'h00, 8'h21, 8'h00, 8'h00});
      end
      step();
      note_row({rows[k], 1'b1, k == 3, 2'b00});
    end
    step();
    note_row({11'h000, 4'b0001});
    // A running record range refuses a play pair; the kind stays after the end
    send('{`VSC_OP_SET_REC, 8'h00, 8'h30, 8'h00, 8'h30, 8'h00, 8'h00});
    note_row({11'h030, 4'b1010});
    send('{`VSC_OP_SET_PLAY, 8'h00, 8'h40, 8'h00, 8'h40, 8'h00, 8'h00});
    note_row({11'h030, 4'b1010});
    step();
    note_row({11'h000, 4'b0011});
    e_err = 1'b1;
    note_cfg();
    results();
  end
endmodule
